// file: design/sac_adc_top.sv
// Purpose: APB register block and control of an 8-bit SAR converter with a resistor ladder
// Assumes: comparator and ladder are analog; pwr_mode comes from logic on sys_clk
// Notes: result nibbles have no reset; they hold until the next conversion ends
//
// Operation
// - twelve inputs, ladder comparison, 8-bit result
// - writing 1 to start flag starts
// - completion stores result, clears start flag
// - ladder current off flag cuts ladder
// - result read-only as two nibbles
// - reset leaves result register untouched
// - result held until next conversion
// - result undefined while conversion runs
// - no conversion in stop, watch, subactive
// - low-power modes always cut ladder current
// - first mode register picks pin function
// - second register sets speed and pins
// - channel register picks converted input
// - reset sets port data to ones
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_adc_top
    import sac_pkg::*;
#(
    parameter int NUM_CH = 12,
    parameter int RES_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] pwr_mode,
    input wire logic cmp_in,
    output logic [RES_W-1:0] ladder_code,
    output logic ladder_en,
    output logic [3:0] chan_sel,
    output logic [NUM_CH-1:0] analog_pin_en,
    output logic [NUM_CH-1:0] pullup_en,
    output logic [NUM_CH-1:0] port_output_data
);
    if (NUM_CH != `SAC_PORT_W || RES_W != 2 * `SAC_NIBBLE_W) begin : g_chk
        $error("sac_adc_top serves twelve channels and an 8-bit result only");
    end

    sac_conv_if #(.RES_W(RES_W)) cv ();

    logic [3:0] channel_select_reg;
    logic [3:0] pin_function_reg_a;
    logic [3:0] speed_pin_reg_b;
    logic conversion_start_flag;
    logic ladder_current_off_flag;
    logic pullup_select_bit;
    logic [3:0] result_low_nibble;
    logic [3:0] result_high_nibble;
    logic [9:0] idx;
    logic wr_acc;
    logic rd_setup;
    logic hit;
    logic low_power;
    logic start_req;
    logic cmp_sync;
    logic [31:0] next_rdata;

    // bus decode on the word index
    assign idx = paddr[11:2];
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;

    // known register indices
    always_comb begin
        if (idx == `SAC_IDX_CHANNEL) begin
            hit = 1'b1;
        end else if (idx == `SAC_IDX_RES_LOW || idx == `SAC_IDX_RES_HIGH) begin
            hit = 1'b1;
        end else if (idx == `SAC_IDX_PIN_FUNC_A || idx == `SAC_IDX_SPEED_PIN_B) begin
            hit = 1'b1;
        end else if (idx == `SAC_IDX_START_FLAG || idx == `SAC_IDX_LADDER_OFF) begin
            hit = 1'b1;
        end else if (idx == `SAC_IDX_PORT_DATA || idx == `SAC_IDX_MISC) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // unmapped addresses answer with an error in the access phase
    assign pslverr = psel && penable && !hit;

    // stop, watch and subactive stop the system clock to the converter
    assign low_power = (pwr_mode == SAC_PWR_STOP) || (pwr_mode == SAC_PWR_WATCH)
                       || (pwr_mode == SAC_PWR_SUBACTIVE);

    assign start_req = wr_acc && (idx == `SAC_IDX_START_FLAG)
                       && pwdata[`SAC_START_BIT] && !conversion_start_flag;

    // comparator pin passes two flops before the sequencer reads it
    sac_sync2 #(.W(1)) u_cmp_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .d(cmp_in),
        .q(cmp_sync)
    );

    assign cv.start = start_req;
    assign cv.fast = speed_pin_reg_b[`SAC_SPEED_BIT];
    assign cv.hold = low_power;
    assign cv.cmp = cmp_sync;

    sac_sar_engine #(.RES_W(RES_W), .CNT_W(8)) u_engine (
        .sys_clk(sys_clk),
        .srst(srst),
        .cv(cv.engine)
    );

    // writable control registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            channel_select_reg <= `SAC_RST_CHANNEL;
            pin_function_reg_a <= `SAC_RST_NIBBLE;
            speed_pin_reg_b <= `SAC_RST_NIBBLE;
            ladder_current_off_flag <= 1'b0;
            pullup_select_bit <= 1'b0;
        end else if (wr_acc) begin
            if (idx == `SAC_IDX_CHANNEL) begin
                channel_select_reg <= pwdata[3:0];
            end else if (idx == `SAC_IDX_PIN_FUNC_A) begin
                pin_function_reg_a <= pwdata[3:0];
            end else if (idx == `SAC_IDX_SPEED_PIN_B) begin
                speed_pin_reg_b <= pwdata[3:0];
            end else if (idx == `SAC_IDX_LADDER_OFF) begin
                ladder_current_off_flag <= pwdata[`SAC_LADDER_OFF_BIT];
            end else if (idx == `SAC_IDX_MISC) begin
                pullup_select_bit <= pwdata[`SAC_PULLUP_SEL_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_output_data <= `SAC_RST_PORT_DATA;
        end else if (wr_acc && idx == `SAC_IDX_PORT_DATA) begin
            port_output_data <= pwdata[`SAC_PORT_W-1:0];
        end
    end

    // flag stands for the whole conversion
    // flag clears when the result lands
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conversion_start_flag <= 1'b0;
        end else if (start_req) begin
            conversion_start_flag <= 1'b1;
        end else if (cv.done) begin
            conversion_start_flag <= 1'b0;
        end
    end

    // no reset term on the result
    always_ff @(posedge sys_clk) begin
        if (cv.done) begin
            result_low_nibble <= cv.result[3:0];
            result_high_nibble <= cv.result[7:4];
        end
    end

    // reads during conversion return the held value
    always_comb begin
        next_rdata = 32'h0;
        if (idx == `SAC_IDX_CHANNEL) begin
            next_rdata[3:0] = channel_select_reg;
        end else if (idx == `SAC_IDX_RES_LOW) begin
            next_rdata[3:0] = result_low_nibble;
        end else if (idx == `SAC_IDX_RES_HIGH) begin
            next_rdata[3:0] = result_high_nibble;
        end else if (idx == `SAC_IDX_PIN_FUNC_A) begin
            next_rdata[3:0] = pin_function_reg_a;
        end else if (idx == `SAC_IDX_SPEED_PIN_B) begin
            next_rdata[3:0] = speed_pin_reg_b;
        end else if (idx == `SAC_IDX_START_FLAG) begin
            next_rdata[`SAC_START_BIT] = conversion_start_flag;
        end else if (idx == `SAC_IDX_LADDER_OFF) begin
            next_rdata[`SAC_LADDER_OFF_BIT] = ladder_current_off_flag;
        end else if (idx == `SAC_IDX_PORT_DATA) begin
            next_rdata[`SAC_PORT_W-1:0] = port_output_data;
        end else if (idx == `SAC_IDX_MISC) begin
            next_rdata[`SAC_PULLUP_SEL_BIT] = pullup_select_bit;
        end
    end

    // read data is captured in the setup phase, valid through access
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ladder_en <= 1'b0;
        end else begin
            ladder_en <= !ladder_current_off_flag && !low_power;
        end
    end

    // channel register drives the input mux
    assign chan_sel = channel_select_reg;
    assign ladder_code = cv.trial;

    // first register: channels 0 to 7 in pairs
    // second register: channels 8 to 11 in pairs
    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_pin
        if (g < 8) begin : g_a
            assign analog_pin_en[g] = pin_function_reg_a[g/2];
        end else begin : g_b
            assign analog_pin_en[g] = speed_pin_reg_b[1 + (g-8)/2];
        end
        // pull-up stays on for a set data bit while the pull-up select bit is set, analog pin or not
        assign pullup_en[g] = pullup_select_bit && port_output_data[g];
    end

    // conversion length tracking for the checks below
    logic [15:0] run_cnt;
    logic run_fast;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run_cnt <= 16'h0;
            run_fast <= 1'b0;
        end else if (start_req) begin
            run_cnt <= 16'h0;
            run_fast <= speed_pin_reg_b[`SAC_SPEED_BIT];
        end else if (conversion_start_flag && (cv.done || !low_power)) begin
            run_cnt <= run_cnt + 16'h1; // finish cycle is never held
        end
    end

    // set by the first completion and never cleared, like the result itself
    logic res_loaded;
    always_ff @(posedge sys_clk) begin
        if (cv.done) begin
            res_loaded <= 1'b1;
        end
    end

    start_launch_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        start_req |=> conversion_start_flag && cv.busy)
        else $error("start write did not launch a conversion");

    done_clear_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        cv.done |=> !conversion_start_flag
        && {result_high_nibble, result_low_nibble} == $past(cv.result))
        else $error("completion did not store result and clear flag");

    ladder_cut_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        ladder_current_off_flag |=> !ladder_en)
        else $error("ladder current on while off flag set");

    lowpower_cut_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        low_power |=> !ladder_en)
        else $error("ladder current on in low-power mode");

    lowpower_hold_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        low_power && cv.busy && !cv.done |=> $stable(cv.trial) && !cv.done)
        else $error("conversion advanced in low-power mode");

    result_hold_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        res_loaded && !cv.done |=> $stable(result_low_nibble) && $stable(result_high_nibble))
        else $error("result changed outside completion");

    conv_len_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        $fell(conversion_start_flag) |-> run_cnt == (run_fast ?
            16'(8 * `SAC_FAST_BIT_CYC + 1) : 16'(8 * `SAC_SLOW_BIT_CYC + 1)))
        else $error("conversion length differs from speed setting");

    port_reset_a: assert property (
        @(posedge sys_clk)
        srst |=> port_output_data == `SAC_RST_PORT_DATA)
        else $error("port data not ones after reset");

    channel_sel_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        wr_acc && idx == `SAC_IDX_CHANNEL |=> chan_sel == $past(pwdata[3:0]))
        else $error("channel select did not follow the write");
endmodule // sac_adc_top

// file: design/sac_consts.svh
// Purpose: named offsets, fields, reset values and timing for the converter control block
// Assumes: 32-bit APB, one aligned word per register, byte address = 4 * index
// Notes: timing counts derive from the printed times and the system clock rate
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register indices; byte address is four times the index
`define SAC_IDX_CHANNEL 10'h016
`define SAC_IDX_RES_LOW 10'h017
`define SAC_IDX_RES_HIGH 10'h018
`define SAC_IDX_PIN_FUNC_A 10'h019
`define SAC_IDX_SPEED_PIN_B 10'h01a
`define SAC_IDX_START_FLAG 10'h020
`define SAC_IDX_LADDER_OFF 10'h021
`define SAC_IDX_PORT_DATA 10'h030
`define SAC_IDX_MISC 10'h031

// field positions
`define SAC_START_BIT 2
`define SAC_LADDER_OFF_BIT 2
`define SAC_PULLUP_SEL_BIT 3
`define SAC_SPEED_BIT 0
`define SAC_NIBBLE_W 4
`define SAC_PORT_W 12

// reset values
`define SAC_RST_NIBBLE 4'h0
`define SAC_RST_PORT_DATA 12'hfff
`define SAC_RST_CHANNEL 4'h0

// timing: time per result bit in ns, clock in MHz
`define SAC_CLK_MHZ 100
`define SAC_SLOW_BIT_NS 320
`define SAC_FAST_BIT_NS 80
`define SAC_SLOW_BIT_CYC ((`SAC_SLOW_BIT_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_FAST_BIT_CYC ((`SAC_FAST_BIT_NS * `SAC_CLK_MHZ + 999) / 1000)

// comparator path latency through the synchroniser
`define SAC_SYNC_LAT 2

`endif

// file: design/sac_conv_if.sv
// Purpose: carries start, speed, comparator and result between control and sequencer
// Assumes: single clock domain
// Notes: cmp is already synchronised when it reaches this interface
`timescale 1ns/1ps
interface sac_conv_if #(parameter int RES_W = 8);
    logic start;
    logic fast;
    logic hold;
    logic cmp;
    logic busy;
    logic done;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;

    modport ctrl (output start, output fast, output hold, output cmp,
                  input busy, input done, input trial, input result);
    modport engine (input start, input fast, input hold, input cmp,
                    output busy, output done, output trial, output result);
endinterface

// file: design/sac_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants come from sac_consts.svh
// Notes: states are gray coded along the conversion path
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'h0,
        SAC_SETTLE = 2'h1,
        SAC_FINISH = 2'h3
    } sac_state_e;

    typedef enum logic [2:0] {
        SAC_PWR_ACTIVE = 3'h0,
        SAC_PWR_STANDBY = 3'h1,
        SAC_PWR_STOP = 3'h2,
        SAC_PWR_WATCH = 3'h3,
        SAC_PWR_SUBACTIVE = 3'h4
    } sac_pwr_e;

endpackage

// file: design/sac_sar_engine.sv
// Purpose: successive-approximation sequencer, one trial bit per settle window
// Assumes: comparator high means the input lies above the trial code
// Notes: hold freezes the sequence in place while the system clock is stopped
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_sar_engine
    import sac_pkg::*;
#(
    parameter int RES_W = 8,
    parameter int CNT_W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    sac_conv_if.engine cv
);
    localparam logic [CNT_W-1:0] SLOW_LOAD = CNT_W'(`SAC_SLOW_BIT_CYC - 1);
    localparam logic [CNT_W-1:0] FAST_LOAD = CNT_W'(`SAC_FAST_BIT_CYC - 1);

    if (`SAC_FAST_BIT_CYC <= `SAC_SYNC_LAT || `SAC_SLOW_BIT_CYC >= (1 << CNT_W)) begin : g_chk
        $error("settle counts do not fit the comparator latency or counter width");
    end

    sac_state_e state;
    logic [$clog2(RES_W)-1:0] bit_idx;
    logic [CNT_W-1:0] cnt;
    logic speed_fast;

    assign cv.busy = (state != SAC_IDLE);
    assign cv.done = (state == SAC_FINISH);

    // sequence: load msb trial, settle, decide, step down to lsb
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= SAC_IDLE;
            bit_idx <= '0;
            cnt <= '0;
            speed_fast <= 1'b0;
            cv.trial <= '0;
            cv.result <= '0;
        end else begin
            case (state)
                SAC_IDLE: begin
                    if (cv.start) begin
                        state <= SAC_SETTLE;
                        speed_fast <= cv.fast;
                        bit_idx <= ($clog2(RES_W))'(RES_W - 1);
                        cnt <= cv.fast ? FAST_LOAD : SLOW_LOAD;
                        cv.trial <= {1'b1, {(RES_W-1){1'b0}}};
                    end
                end
                SAC_SETTLE: begin
                    if (!cv.hold) begin
                        if (cnt != '0) begin
                            cnt <= cnt - 1'b1;
                        end else begin
                            cnt <= speed_fast ? FAST_LOAD : SLOW_LOAD;
                            if (bit_idx == '0) begin
                                state <= SAC_FINISH;
                                cv.result <= {cv.trial[RES_W-1:1], cv.cmp};
                            end else begin
                                cv.trial[bit_idx] <= cv.cmp;
                                cv.trial[bit_idx - 1'b1] <= 1'b1;
                                bit_idx <= bit_idx - 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state <= SAC_IDLE;
                end
            endcase
        end
    end
endmodule // sac_sar_engine

// file: design/sac_sync2.sv
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
module sac_sync2 #(parameter int W = 1) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // two stages, cleared by reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sac_sync2

// file: tb/tb.sv
// Purpose: self-checking bench for the converter control block over APB
// Assumes: APB slave may add wait states, comparator modelled from ladder_code
// Notes: the analog input sits half a step above ain so any compare convention gives ain
`timescale 1ns/1ps
`include "sac_consts.svh"
module tb
    import sac_pkg::*;
;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] pwr_mode = 3'h0;
    logic cmp_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] ladder_code;
    logic ladder_en;
    logic [3:0] chan_sel;
    logic [11:0] analog_pin_en;
    logic [11:0] pullup_en;
    logic [11:0] port_output_data;
    logic [7:0] ain = 8'ha5;
    int error_cnt = 0;
    int total_checks = 0;

    // free running system clock, 10 ns period
    always #5 sys_clk = ~sys_clk;

    // comparator model: high while the input lies above the trial code
    always @(posedge sys_clk) cmp_in <= (ladder_code <= ain);

    sac_adc_top #(.NUM_CH(12), .RES_W(8)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwr_mode(pwr_mode), .cmp_in(cmp_in),
        .ladder_code(ladder_code), .ladder_en(ladder_en), .chan_sel(chan_sel),
        .analog_pin_en(analog_pin_en), .pullup_en(pullup_en),
        .port_output_data(port_output_data)
    );

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] d);
        logic e;
        apb(1'b0, idx, 32'h0, d, e);
    endtask

    task automatic chk_result(input logic [7:0] a);
        logic [31:0] d;
        rd(`SAC_IDX_RES_LOW, d);
        chk_reg("result low", {28'h0, a[3:0]}, d);
        rd(`SAC_IDX_RES_HIGH, d);
        chk_reg("result high", {28'h0, a[7:4]}, d);
    endtask

    // reset values of control registers and pins
    task automatic t_reset_vals();
        logic [9:0] ix[6];
        logic [31:0] d;
        ix = '{`SAC_IDX_CHANNEL, `SAC_IDX_PIN_FUNC_A, `SAC_IDX_SPEED_PIN_B,
               `SAC_IDX_START_FLAG, `SAC_IDX_LADDER_OFF, `SAC_IDX_MISC};
        foreach (ix[i]) begin
            rd(ix[i], d);
            chk_reg("reset word", 32'h0, d);
        end
        rd(`SAC_IDX_PORT_DATA, d);
        chk_reg("port data reg", 32'hfff, d);
        chk_pin("port data pins", 12'hfff, port_output_data);
        chk_pin("pullup", 12'h000, pullup_en);
    endtask

    // pin function, pull-up and channel selection
    task automatic t_pins();
        logic [31:0] d;
        wr(`SAC_IDX_MISC, 32'h8);
        chk_pin("pullup on", 12'hfff, pullup_en);
        wr(`SAC_IDX_PORT_DATA, 32'h0f0);
        chk_pin("pullup part", 12'h0f0, pullup_en);
        wr(`SAC_IDX_PIN_FUNC_A, 32'h5);
        wr(`SAC_IDX_SPEED_PIN_B, 32'h2);
        chk_pin("analog pins", 12'h333, analog_pin_en);
        rd(`SAC_IDX_PIN_FUNC_A, d);
        chk_reg("pin fn a", 32'h5, d);
        wr(`SAC_IDX_CHANNEL, 32'hb);
        chk_pin("channel", 12'h00b, {8'h0, chan_sel});
    endtask

    // one conversion of a at s cycles per bit
    task automatic conv(input logic [7:0] a, input int s, input logic len);
        logic [31:0] d;
        ain <= a;
        wr(`SAC_IDX_START_FLAG, 32'h4);
        rd(`SAC_IDX_START_FLAG, d);
        chk_reg("flag set", 32'h1, {31'h0, d[2]});
        chk_pin("trial msb", 12'h080, {4'h0, ladder_code});
        chk_pin("ladder enable", {11'h0, len}, {11'h0, ladder_en});
        repeat (8 * s - 12) @(posedge sys_clk);
        rd(`SAC_IDX_START_FLAG, d);
        chk_reg("flag held", 32'h1, {31'h0, d[2]});
        repeat (8) @(posedge sys_clk);
        rd(`SAC_IDX_START_FLAG, d);
        chk_reg("flag cleared", 32'h0, {31'h0, d[2]});
        chk_result(a);
    endtask

    // low-power modes freeze the conversion and cut the ladder
    task automatic t_lowpower();
        sac_pwr_e lp[3];
        logic [31:0] d;
        lp = '{SAC_PWR_STOP, SAC_PWR_WATCH, SAC_PWR_SUBACTIVE};
        ain <= 8'h96;
        wr(`SAC_IDX_START_FLAG, 32'h4);
        repeat (10) @(posedge sys_clk);
        foreach (lp[i]) begin
            pwr_mode <= lp[i];
            repeat (3) @(posedge sys_clk);
            chk_pin("ladder low power", 12'h0, {11'h0, ladder_en});
            repeat (17) @(posedge sys_clk);
        end
        pwr_mode <= SAC_PWR_ACTIVE;
        rd(`SAC_IDX_START_FLAG, d);
        chk_reg("flag frozen", 32'h1, {31'h0, d[2]});
        repeat (60) @(posedge sys_clk);
        rd(`SAC_IDX_START_FLAG, d);
        chk_reg("flag after stall", 32'h0, {31'h0, d[2]});
        chk_result(8'h96);
    endtask

    // result holds, ignores writes and survives a reset
    task automatic t_hold_reset();
        logic [31:0] d;
        ain <= 8'h11;
        repeat (20) @(posedge sys_clk);
        chk_result(8'h96);
        wr(`SAC_IDX_RES_LOW, 32'hf);
        chk_result(8'h96);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk_result(8'h96);
        rd(`SAC_IDX_PORT_DATA, d);
        chk_reg("port data again", 32'hfff, d);
    endtask

    // an unmapped index answers with an error and reads zero
    task automatic t_unmapped();
        logic [31:0] d;
        logic e;
        apb(1'b0, 10'h3ff, 32'h0, d, e);
        chk_reg("unmapped err", 32'h1, {31'h0, e});
        chk_reg("unmapped data", 32'h0, d);
        apb(1'b0, `SAC_IDX_CHANNEL, 32'h0, d, e);
        chk_reg("mapped err", 32'h0, {31'h0, e});
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset_vals();
        t_pins();
        wr(`SAC_IDX_SPEED_PIN_B, 32'h0);
        conv(8'ha5, 32, 1'b1);
        wr(`SAC_IDX_SPEED_PIN_B, 32'h1);
        conv(8'h5a, 8, 1'b1);
        conv(8'hff, 8, 1'b1);
        pwr_mode <= SAC_PWR_STANDBY;
        conv(8'h00, 8, 1'b1);
        wr(`SAC_IDX_LADDER_OFF, 32'h4);
        conv(8'h3c, 8, 1'b0);
        wr(`SAC_IDX_LADDER_OFF, 32'h0);
        t_lowpower();
        t_hold_reset();
        t_unmapped();
        test_done();
    end

    // watchdog cuts a hang short
    initial begin
        #100000;
        error_cnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        test_done();
    end
endmodule // tb
